/* File: inc/ssfs_params.svh */
// constants for the sleep-state fault sequencer: offsets, fields, reset values, counts
// assumes a single pclk domain; counts are in pclk cycles
`ifndef SSFS_PARAMS_SVH
`define SSFS_PARAMS_SVH

// ==================================================
// register map (byte addresses on APB)
`define SSFS_CTRL_OFFSET 12'h000
`define SSFS_STATUS_OFFSET 12'h004
`define SSFS_ADDR_W 12
`define SSFS_CTRL_RESET 1'b0
`define SSFS_CTRL_FORCE_OFF_BIT 0

// ==================================================
// rail indices
`define SSFS_NRAILS 5
`define SSFS_RAIL_MEM_IO 0
`define SSFS_RAIL_HUB_UPPER 1
`define SSFS_RAIL_HUB_LOWER 2
`define SSFS_RAIL_HOST_TERM 3
`define SSFS_RAIL_MEM_TERM 4

// ==================================================
// timing and fault counts
`define SSFS_SOFT_START_CYCLES 2048
`define SSFS_RESET_SS_CYCLES 3
`define SSFS_FAULT_RESET_CYCLES 16384
`define SSFS_FAULT_LIMIT_COLD 3'h4
`define SSFS_FAULT_LIMIT_WARM 3'h5
`define SSFS_FAULT_CNT_MAX 3'h7

`endif

/* File: inc/ssfs_pkg.sv */
// types for the sleep-state fault sequencer
// assumes ssfs_params.svh is compiled alongside for the numeric constants
package ssfs_pkg;

  // ==================================================
  // sequencer states
  typedef enum logic [2:0] {
    SSFS_OFF,      // internal S5, also shutdown latches
    SSFS_RESET,    // error amplifier held in reset
    SSFS_SEQ,      // staged soft-start
    SSFS_ON,       // S0, all rails up
    SSFS_SLEEP,    // S3, memory I/O rail only
    SSFS_RETRY     // hiccup wait before restarting faulted rails
  } ssfs_state_e_t;

  // ==================================================
  // whole module state
  typedef struct packed {
    ssfs_state_e_t state;
    logic [4:0] en;
    logic [1:0] stage;
    logic [13:0] tmr;
    logic [14:0] frc;
    logic [2:0] fcnt;
    logic from_s5;
    logic ov_l;
    logic th_l;
    logic th_seen_low;
    logic shut_l;
    logic pg;
    logic amp_rst;
    logic hs;
    logic ls;
    logic ctrl_off;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ssfs_state_t;

endpackage : ssfs_pkg

/* File: hw/ssfs_sequencer.sv */
// digital supervisor of a multi-rail memory power regulator: sleep-state
// sequencing, soft-start, fault counting, latched shutdowns, gate interlock
// assumes comparator and sleep inputs already synchronous to pclk
//
// Added by the designer: the APB register port and the placing of the registers.
`include "ssfs_params.svh"
`timescale 1ns/100ps
`default_nettype none

module ssfs_sequencer #(
  parameter int SS_CYCLES = `SSFS_SOFT_START_CYCLES,          // one soft-start cycle
  parameter int FAULT_RESET_CYCLES = `SSFS_FAULT_RESET_CYCLES  // leaky window
) (
  input wire logic pclk,                        // 200 MHz clock
  input wire logic presetn,                     // async reset, active low
  input wire logic psel,                        // apb select
  input wire logic penable,                     // apb access phase
  input wire logic pwrite,                      // apb write
  input wire logic [11:0] paddr,                // apb byte address
  input wire logic [31:0] pwdata,               // apb write data
  output logic [31:0] prdata,                   // apb read data
  output logic pready,                          // apb ready
  output logic pslverr,                         // apb error, unmapped address
  input wire logic suspend_to_ram_request_n,    // low requests S3
  input wire logic soft_off_request_n,          // low requests S4/S5
  input wire logic por12_ok,                    // 12 V above reset threshold
  input wire logic [4:0] rail_in_reg,           // per-rail in regulation
  input wire logic [4:0] rail_uv,               // per-rail under-voltage
  input wire logic ov_memory_io_rail,           // memory I/O over-voltage
  input wire logic ov_memory_termination_rail,  // termination over-voltage
  input wire logic oc_memory_io_rail,           // high-side drop over threshold
  input wire logic temp_trip_hot,               // junction reached trip point
  input wire logic temp_below_release,          // junction below release point
  input wire logic pwm_high_req,                // modulator wants high side on
  input wire logic high_side_gate_off,          // high-side gate sensed off
  input wire logic low_side_gate_off,           // low-side gate sensed off
  output logic [4:0] rail_en,                   // per-rail enable
  output logic error_amp_reset,                 // shorts comp to feedback
  output logic term_ref_short,                  // termination reference to rail
  output logic term_rail_power_good,            // host termination power-good
  output logic high_side_gate,                  // high-side drive on
  output logic low_side_gate                    // low-side drive on
);

  // ==================================================
  // derived constants
  localparam logic [13:0] SS_LAST = 14'(SS_CYCLES - 1);
  localparam logic [13:0] RESET_LAST = 14'(`SSFS_RESET_SS_CYCLES * SS_CYCLES - 1);
  localparam logic [14:0] FR_LAST = 15'(FAULT_RESET_CYCLES - 1);
  localparam logic [4:0] IO_MASK = 5'(1 << `SSFS_RAIL_MEM_IO);

  ssfs_pkg::ssfs_state_t s_q;
  ssfs_pkg::ssfs_state_t s_d;

  // number of set bits, for several rails faulting in one cycle
  function automatic logic [2:0] ssfs_popcount(input logic [4:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < 5; i++) begin
      n = n + {2'b00, v[i]};
    end
    return n;
  endfunction : ssfs_popcount

  // ==================================================
  // next state
  always_comb begin
    logic s5_req;
    logic s3_req;
    logic active;
    logic [4:0] flt;
    logic [3:0] sum;
    logic [2:0] limit;
    logic [4:0] stage_mask;
    logic [4:0] stage_done;
    logic apb_setup;
    logic apb_wr;
    s5_req = 1'b0;
    s3_req = 1'b0;
    active = 1'b0;
    flt = 5'h00;
    sum = 4'h0;
    limit = 3'h0;
    stage_mask = 5'h00;
    stage_done = 5'h00;
    apb_setup = 1'b0;
    apb_wr = 1'b0;
    s_d = s_q;

    // software force-off behaves as a soft-off request
    s5_req = !soft_off_request_n || s_q.ctrl_off;
    s3_req = !suspend_to_ram_request_n;

    // sticky over-voltage latch; set wins over the S5 clear
    if (s5_req) begin
      s_d.ov_l = 1'b0;
      s_d.shut_l = 1'b0;
    end
    if ((ov_memory_io_rail && s_q.en[`SSFS_RAIL_MEM_IO]) ||
        (ov_memory_termination_rail && s_q.en[`SSFS_RAIL_MEM_TERM])) begin
      s_d.ov_l = 1'b1;
    end

    // thermal latch: release needs cool plus a soft-off low then high
    if (s_q.th_l && !soft_off_request_n) begin
      s_d.th_seen_low = 1'b1;
    end
    if (s_q.th_l && s_q.th_seen_low && soft_off_request_n && temp_below_release) begin
      s_d.th_l = 1'b0;
      s_d.th_seen_low = 1'b0;
    end
    if (temp_trip_hot) begin
      s_d.th_l = 1'b1;
      s_d.th_seen_low = 1'b0;
    end

    // leaky fault window counts every cycle
    if (s_q.frc == FR_LAST) begin
      s_d.frc = 15'h0000;
      s_d.fcnt = 3'h0;
    end else begin
      s_d.frc = s_q.frc + 15'h0001;
    end

    // per-rail faults while sequencing, running or in the hiccup wait
    active = (s_q.state == ssfs_pkg::SSFS_SEQ) || (s_q.state == ssfs_pkg::SSFS_ON) ||
             (s_q.state == ssfs_pkg::SSFS_RETRY);
    if (active) begin
      flt = rail_uv & s_q.en;
      flt[`SSFS_RAIL_MEM_IO] = flt[`SSFS_RAIL_MEM_IO] ||
                               (oc_memory_io_rail && s_q.en[`SSFS_RAIL_MEM_IO]);
      // termination fed from memory I/O, lower hub stage fed from upper
      flt[`SSFS_RAIL_MEM_TERM] = flt[`SSFS_RAIL_MEM_TERM] ||
        (s_q.en[`SSFS_RAIL_MEM_TERM] && !s_q.en[`SSFS_RAIL_MEM_IO]);
      flt[`SSFS_RAIL_HUB_LOWER] = flt[`SSFS_RAIL_HUB_LOWER] ||
        (s_q.en[`SSFS_RAIL_HUB_LOWER] && !s_q.en[`SSFS_RAIL_HUB_UPPER]);
    end
    if (flt != 5'h00) begin
      s_d.en = s_q.en & ~flt;
      s_d.frc = 15'h0000;
      sum = {1'b0, s_q.fcnt} + {1'b0, ssfs_popcount(flt)};
      // saturate rather than wrap
      s_d.fcnt = sum[3] ? `SSFS_FAULT_CNT_MAX : sum[2:0];
      s_d.state = ssfs_pkg::SSFS_RETRY;
      s_d.tmr = 14'h0000;
      s_d.pg = 1'b0;
      limit = s_q.from_s5 ? `SSFS_FAULT_LIMIT_COLD : `SSFS_FAULT_LIMIT_WARM;
      if (s_d.fcnt >= limit) begin
        s_d.shut_l = 1'b1;
      end
    end

    // stage membership in start order
    case (s_q.stage)
      2'd0: stage_mask = 5'(1 << `SSFS_RAIL_MEM_IO) | 5'(1 << `SSFS_RAIL_HUB_UPPER);
      2'd1: stage_mask = 5'(1 << `SSFS_RAIL_HUB_LOWER);
      2'd2: stage_mask = 5'(1 << `SSFS_RAIL_HOST_TERM);
      default: stage_mask = 5'(1 << `SSFS_RAIL_MEM_TERM);
    endcase
    stage_done = stage_mask & ~rail_in_reg;

    // sleep-state machine
    if (s_d.ov_l || s_d.th_l || s_d.shut_l) begin
      s_d.state = ssfs_pkg::SSFS_OFF;
      s_d.en = 5'h00;
      s_d.pg = 1'b0;
      s_d.amp_rst = 1'b0;
    end else begin
      case (s_q.state)
        ssfs_pkg::SSFS_OFF: begin
          s_d.en = 5'h00;
          s_d.pg = 1'b0;
          s_d.amp_rst = 1'b0;
          if (!s5_req && !s3_req && por12_ok) begin
            s_d.state = ssfs_pkg::SSFS_RESET;
            s_d.from_s5 = 1'b1;
            s_d.tmr = 14'h0000;
            s_d.amp_rst = 1'b1;
          end
        end
        ssfs_pkg::SSFS_SLEEP: begin
          if (s5_req) begin
            s_d.state = ssfs_pkg::SSFS_OFF;
            s_d.en = 5'h00;
          end else if (!s3_req && por12_ok) begin
            s_d.state = ssfs_pkg::SSFS_RESET;
            s_d.from_s5 = 1'b0;
            s_d.tmr = 14'h0000;
            s_d.amp_rst = 1'b1;
          end
        end
        ssfs_pkg::SSFS_RESET: begin
          if (s5_req) begin
            s_d.state = ssfs_pkg::SSFS_OFF;
            s_d.en = 5'h00;
            s_d.amp_rst = 1'b0;
          end else if (s3_req) begin
            s_d.state = s_q.en[`SSFS_RAIL_MEM_IO] ? ssfs_pkg::SSFS_SLEEP : ssfs_pkg::SSFS_OFF;
            s_d.amp_rst = 1'b0;
          end else if (s_q.tmr == RESET_LAST) begin
            s_d.state = ssfs_pkg::SSFS_SEQ;
            s_d.amp_rst = 1'b0;
            s_d.stage = 2'd0;
            s_d.tmr = 14'h0000;
          end else begin
            s_d.tmr = s_q.tmr + 14'h0001;
          end
        end
        ssfs_pkg::SSFS_SEQ, ssfs_pkg::SSFS_ON, ssfs_pkg::SSFS_RETRY: begin
          if (s5_req) begin
            s_d.state = ssfs_pkg::SSFS_OFF;
            s_d.en = 5'h00;
            s_d.pg = 1'b0;
          end else if (s3_req) begin
            s_d.state = ssfs_pkg::SSFS_SLEEP;
            s_d.en = s_q.en & IO_MASK;
            s_d.pg = 1'b0;
          end else if (flt != 5'h00) begin
            // fault handling above already chose the hiccup wait
          end else if (s_q.state == ssfs_pkg::SSFS_RETRY) begin
            if (s_q.tmr == SS_LAST) begin
              s_d.state = ssfs_pkg::SSFS_SEQ;
              s_d.stage = 2'd0;
              s_d.tmr = 14'h0000;
            end else begin
              s_d.tmr = s_q.tmr + 14'h0001;
            end
          end else if (s_q.state == ssfs_pkg::SSFS_SEQ) begin
            // or-in only, so rails already regulating stay untouched
            s_d.en = s_q.en | stage_mask;
            if (s_q.en[`SSFS_RAIL_MEM_TERM] && s_q.stage == 2'd3) begin
              if (s_q.tmr == SS_LAST) begin
                s_d.state = ssfs_pkg::SSFS_ON;
                s_d.from_s5 = 1'b0;
              end else begin
                s_d.tmr = s_q.tmr + 14'h0001;
              end
            end else if (s_q.stage != 2'd3 && (s_q.en & stage_mask) == stage_mask &&
                         stage_done == 5'h00) begin
              s_d.stage = s_q.stage + 2'd1;
            end
          end else begin
            s_d.pg = rail_in_reg[`SSFS_RAIL_HOST_TERM];
          end
        end
        default: begin
          s_d.state = ssfs_pkg::SSFS_OFF;
          s_d.en = 5'h00;
        end
      endcase
    end

    // interlocked gate drive; each side waits for the other to sense off
    s_d.hs = s_d.en[`SSFS_RAIL_MEM_IO] && pwm_high_req && low_side_gate_off &&
             !s_q.ls;
    s_d.ls = s_d.en[`SSFS_RAIL_MEM_IO] && !pwm_high_req && high_side_gate_off &&
             !s_q.hs;

    // apb slave: setup cycle loads data, access cycle answers with pready
    apb_setup = psel && !penable;
    apb_wr = psel && penable && s_q.pready && pwrite;
    s_d.pready = apb_setup;
    if (apb_setup) begin
      s_d.prdata = 32'h0000_0000;
      s_d.pslverr = 1'b0;
      case (paddr)
        `SSFS_CTRL_OFFSET: s_d.prdata[`SSFS_CTRL_FORCE_OFF_BIT] = s_q.ctrl_off;
        `SSFS_STATUS_OFFSET: s_d.prdata = {10'h000, s_q.pg, s_q.en, s_q.shut_l,
                                           s_q.th_l, s_q.ov_l, s_q.from_s5, 4'h0,
                                           1'b0, s_q.fcnt, 1'b0, s_q.state};
        default: s_d.pslverr = 1'b1;
      endcase
    end
    if (apb_wr && paddr == `SSFS_CTRL_OFFSET) begin
      s_d.ctrl_off = pwdata[`SSFS_CTRL_FORCE_OFF_BIT];
    end
  end

  // ==================================================
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{state: ssfs_pkg::SSFS_OFF, en: 5'h00, stage: 2'd0, tmr: 14'h0000,
               frc: 15'h0000, fcnt: 3'h0, from_s5: 1'b0, ov_l: 1'b0, th_l: 1'b0,
               th_seen_low: 1'b0, shut_l: 1'b0, pg: 1'b0, amp_rst: 1'b0, hs: 1'b0,
               ls: 1'b0, ctrl_off: `SSFS_CTRL_RESET, pready: 1'b0, pslverr: 1'b0,
               prdata: 32'h0000_0000};
    end else begin
      s_q <= s_d;
    end
  end

  // ==================================================
  // outputs straight from the state register
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign rail_en = s_q.en;
  assign error_amp_reset = s_q.amp_rst;
  assign term_ref_short = !s_q.en[`SSFS_RAIL_MEM_TERM];
  assign term_rail_power_good = s_q.pg;
  assign high_side_gate = s_q.hs;
  assign low_side_gate = s_q.ls;

endmodule : ssfs_sequencer

`default_nettype wire

/* File: verification/ssfs_rail_model.sv */
// far-side model: rail comparators and gate sense around the sequencer
// assumes rails regulate a few cycles after enable; slow stretches the ramp
`timescale 1ns/100ps
`default_nettype none
module ssfs_rail_model (
  input wire logic pclk, // clock
  input wire logic slow, // slow ramps
  input wire logic [4:0] rail_en, // enables
  input wire logic high_side_gate, // hs drive
  input wire logic low_side_gate, // ls drive
  output logic [4:0] rail_in_reg, // regulation
  output logic high_side_gate_off, // hs sensed off
  output logic low_side_gate_off // ls sensed off
);
  // ==========
  // ramp ages; a disabled rail drops out of regulation at once
  int age[5];
  initial begin
    rail_in_reg = 5'h00;
    high_side_gate_off = 1'b1;
    low_side_gate_off = 1'b1;
  end
  always @(posedge pclk) begin
    for (int i = 0; i < 5; i++) begin
      age[i] <= rail_en[i] ? age[i] + 1 : 0;
      rail_in_reg[i] <= rail_en[i] && age[i] >= (slow ? 6 : 1);
    end
    // sense lags drive a cycle, as a discharging gate would
    high_side_gate_off <= !high_side_gate;
    low_side_gate_off <= !low_side_gate;
  end
endmodule : ssfs_rail_model
`default_nettype wire

/* File: verification/ssfs_sequencer_chk.sv */
// checker: sequencing, fault and gate interlock properties
// assumes binding onto ssfs_sequencer, one pclk domain
`timescale 1ns/100ps
`default_nettype none
module ssfs_sequencer_chk #(
  parameter int SS_CYCLES = 2048 // soft-start length
) (
  input wire logic pclk, // clock
  input wire logic presetn, // reset
  input wire logic suspend_to_ram_request_n, // s3 req
  input wire logic soft_off_request_n, // s5 req
  input wire logic [4:0] rail_uv, // uv
  input wire logic ov_memory_termination_rail, // ov
  input wire logic oc_memory_io_rail, // oc
  input wire logic temp_trip_hot, // hot
  input wire logic low_side_gate_off, // sense
  input wire logic [4:0] rail_en, // enables
  input wire logic error_amp_reset, // amp reset
  input wire logic term_ref_short, // ref short
  input wire logic term_rail_power_good, // pg
  input wire logic high_side_gate, // hs
  input wire logic low_side_gate // ls
);
  // ==========
  // run-length counters; mt_q saturates so a long run cannot wrap to a false low, amp_q wraps
  logic [15:0] amp_q, amp_d, mt_q, mt_d;
  always_comb begin
    amp_d = error_amp_reset ? amp_q + 16'h0001 : 16'h0000;
    mt_d = !rail_en[4] ? 16'h0000 : (mt_q == 16'hFFFF ? mt_q : mt_q + 16'h0001);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amp_q <= 16'h0000;
      mt_q <= 16'h0000;
    end else begin
      amp_q <= amp_d;
      mt_q <= mt_d;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_oc_hit;
    oc_memory_io_rail && rail_en[0] && soft_off_request_n && suspend_to_ram_request_n;
  endsequence
  sequence s_hiccup;
    !rail_en[0] ##[1:300] rail_en[0];
  endsequence
  // ==========
  // properties
  AST_REF_SHORT: assert property (term_ref_short == !rail_en[4])
    else $error("ref short wrong");
  AST_NO_SHOOT: assert property (!(high_side_gate && low_side_gate))
    else $error("both gates on");
  AST_HS_SENSE: assert property ($rose(high_side_gate) |-> $past(low_side_gate_off))
    else $error("hs on without ls off");
  AST_RESET_QUIET: assert property (error_amp_reset |-> rail_en[4:1] == 4'h0)
    else $error("rail on during reset");
  AST_RESET_LEN: assert property ($fell(error_amp_reset) && soft_off_request_n |-> amp_q == 16'(3 * SS_CYCLES))
    else $error("reset phase length");
  AST_S3_ENTRY: assert property ($fell(suspend_to_ram_request_n) && soft_off_request_n && term_rail_power_good
    |=> rail_en == 5'h01 && !term_rail_power_good)
    else $error("s3 entry");
  AST_S5_OFF: assert property (!soft_off_request_n |=> rail_en == 5'h00 && !term_rail_power_good)
    else $error("s5 not off");
  AST_OV_SHUT: assert property (ov_memory_termination_rail && rail_en[4] |=> rail_en == 5'h00)
    else $error("ov no shutdown");
  AST_HOT_SHUT: assert property (temp_trip_hot |=> rail_en == 5'h00)
    else $error("hot no shutdown");
  AST_UV_DROP: assert property ((rail_uv & rail_en) != 5'h00 && soft_off_request_n && suspend_to_ram_request_n
    |=> (rail_en & $past(rail_uv)) == 5'h00)
    else $error("uv rail kept");
  AST_FEED_LOSS: assert property ($fell(rail_en[0]) && rail_en[4] |=> !rail_en[4])
    else $error("fed rail kept");
  AST_PG_DELAY: assert property ($rose(term_rail_power_good) |-> mt_q >= 16'(SS_CYCLES))
    else $error("pg too early");
  AST_OC_HICCUP: assert property (s_oc_hit |=> s_hiccup)
    else $error("oc no hiccup");
endmodule : ssfs_sequencer_chk
bind ssfs_sequencer ssfs_sequencer_chk #(.SS_CYCLES(SS_CYCLES)) u_chk (
  .pclk, .presetn, .suspend_to_ram_request_n, .soft_off_request_n, .rail_uv, .ov_memory_termination_rail,
  .oc_memory_io_rail, .temp_trip_hot, .low_side_gate_off, .rail_en, .error_amp_reset, .term_ref_short,
  .term_rail_power_good, .high_side_gate, .low_side_gate
);
`default_nettype wire

/* File: verification/tb_top.sv */
// self-checking bench for the sleep-state sequencer
// assumes the rail model on the far side and the bound checker
`include "ssfs_params.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  // ==========
  // signals; counts scaled down to keep the run short
  localparam int SS = 8;
  localparam int FR = 256;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, e, error_amp_reset, term_ref_short, term_rail_power_good, high_side_gate, low_side_gate;
  logic suspend_to_ram_request_n = 1'b0, soft_off_request_n = 1'b0, por12_ok = 1'b0, pwm_high_req = 1'b0;
  logic ov_memory_io_rail = 1'b0, ov_memory_termination_rail = 1'b0, oc_memory_io_rail = 1'b0;
  logic temp_trip_hot = 1'b0, temp_below_release = 1'b1, high_side_gate_off, low_side_gate_off;
  logic [4:0] rail_in_reg, rail_uv = 5'h00, rail_en;
  int err_count = 0, num_checks = 0, exp_f = 0;
  ssfs_sequencer #(.SS_CYCLES(SS), .FAULT_RESET_CYCLES(FR)) uut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .suspend_to_ram_request_n, .soft_off_request_n, .por12_ok, .rail_in_reg, .rail_uv, .ov_memory_io_rail,
    .ov_memory_termination_rail, .oc_memory_io_rail, .temp_trip_hot, .temp_below_release, .pwm_high_req,
    .high_side_gate_off, .low_side_gate_off, .rail_en, .error_amp_reset, .term_ref_short,
    .term_rail_power_good, .high_side_gate, .low_side_gate
  );
  ssfs_rail_model u_far (.pclk, .slow, .rail_en, .high_side_gate, .low_side_gate, .rail_in_reg,
    .high_side_gate_off, .low_side_gate_off);
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  // random modulator demand keeps the gate interlock busy
  always @(posedge pclk) begin
    pwm_high_req <= 1'($urandom);
  end
  // ==========
  // tasks
  task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] y);
    num_checks++;
    if (y !== x) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, x, y);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  // trailing edge keeps a back-to-back call from rewriting psel in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    // a bus that never answers counts as a mismatch
    if (pready !== 1'b1) begin
      err_count++;
      $display("[FAIL] pready expected 1 seen %b", pready);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic up();
    int n = 0;
    while (term_rail_power_good !== 1'b1 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    chk("powered", 8'h3F, 8'({term_rail_power_good, rail_en}));
  endtask : up
  // reference model of a wake: reset length, then the stage queue
  task automatic wake();
    int n = 0;
    logic [4:0] q[$] = '{5'h03, 5'h07, 5'h0F, 5'h1F};
    logic [4:0] last;
    slow <= 1'($urandom);
    while (error_amp_reset !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    n = 0;
    while (error_amp_reset === 1'b1 && n < 1000) begin
      @(posedge pclk);
      n++;
    end
    chk("reset len", 8'(3 * SS), 8'(n));
    last = rail_en;
    n = 0;
    while (q.size() > 0 && n < 300) begin
      @(posedge pclk);
      n++;
      if (rail_en !== last) begin
        last = rail_en;
        chk("stage", 8'(q.pop_front()), 8'(rail_en));
      end
    end
    // stages left over mean the sequence stalled
    chk("stages left", 8'h00, 8'(q.size()));
    up();
  endtask : wake
  task automatic fault(input logic [7:0] m);
    {temp_trip_hot, oc_memory_io_rail, ov_memory_termination_rail, rail_uv} <= m;
    @(posedge pclk);
    {temp_trip_hot, oc_memory_io_rail, ov_memory_termination_rail, rail_uv} <= 8'h00;
    @(posedge pclk);
  endtask : fault
  task automatic s5_cycle();
    soft_off_request_n <= 1'b0;
    tick(2);
    chk("s5 off", 8'h00, 8'({term_rail_power_good, rail_en}));
    soft_off_request_n <= 1'b1;
  endtask : s5_cycle
  task automatic count_chk(input string nm);
    apb(1'b0, `SSFS_STATUS_OFFSET, 32'h0);
    chk(nm, 8'(exp_f), 8'(r[6:4]));
  endtask : count_chk
  task automatic end_of_test();
    if (err_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  // watchdog: about twenty times the expected run
  initial begin
    #100000;
    err_count++;
    end_of_test();
  end
  // ==========
  // scenarios
  initial begin
    void'($urandom(32'h09C5BD04));
    tick(10);
    presetn <= 1'b1;
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped err", 8'h01, 8'(e));
    chk("unmapped data", 8'h00, 8'(r));
    {suspend_to_ram_request_n, soft_off_request_n} <= 2'h3;
    tick(20);
    chk("idle s5", 8'h00, 8'({error_amp_reset, rail_en}));
    por12_ok <= 1'b1;
    wake();
    suspend_to_ram_request_n <= 1'b0;
    tick(2);
    chk("s3 rails", 8'h01, 8'(rail_en));
    chk("s3 pg", 8'h00, 8'(term_rail_power_good));
    chk("s3 ref", 8'h01, 8'(term_ref_short));
    por12_ok <= 1'b0;
    suspend_to_ram_request_n <= 1'b1;
    tick(20);
    chk("por wait", 8'h01, 8'({error_amp_reset, rail_en}));
    por12_ok <= 1'b1;
    wake();
    fault(8'h04);
    chk("uv only", 8'h1B, 8'(rail_en));
    exp_f = 1;
    count_chk("uv count");
    up();
    tick(FR + 8);
    exp_f = 0;
    count_chk("leak clear");
    fault(8'h40);
    chk("oc rail", 8'h1E, 8'(rail_en));
    tick(1);
    chk("feed loss", 8'h0E, 8'(rail_en));
    exp_f = 2;
    count_chk("oc count");
    up();
    s5_cycle();
    wake();
    fault(8'h20);
    tick(40);
    chk("ov latch", 8'h00, 8'({error_amp_reset, rail_en}));
    s5_cycle();
    wake();
    temp_below_release <= 1'b0;
    fault(8'h80);
    s5_cycle();
    tick(40);
    chk("hot latch", 8'h00, 8'({error_amp_reset, rail_en}));
    temp_below_release <= 1'b1;
    s5_cycle();
    wake();
    apb(1'b1, `SSFS_CTRL_OFFSET, 32'h1);
    tick(2);
    chk("force off", 8'h00, 8'(rail_en));
    apb(1'b1, `SSFS_CTRL_OFFSET, 32'h0);
    wake();
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
